// [uart_s2_pkg.sv]
package uart_s2_pkg;

  // ----------------------------------------
  // Register indexes (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_BAUD = 6'h01;
  localparam logic [5:0] IDX_DATA = 6'h02;
  localparam logic [5:0] IDX_STAT1 = 6'h03;
  localparam logic [5:0] IDX_MASK = 6'h04;
  localparam logic [5:0] IDX_STAT2 = 6'h05;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int S2_BRK = 7;
  localparam int S2_EDGE = 6;
  localparam int S2_BIT_ORDER_REVERSE = 5;
  localparam int S2_RECEIVE_INVERT = 4;
  localparam int S2_WAKE = 3;
  localparam int S2_LONG_BREAK_DETECT_ENABLE = 1;
  localparam int S1_RECEIVE_FULL_FLAG = 3;
  localparam int S1_W = 5;

  // ----------------------------------------
  // Reset values and frame counts
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0010;
  localparam logic [3:0] BASE_CHAR_BITS = 4'h8;
  localparam logic [3:0] FRAME_OVERHEAD = 4'h2;
  localparam logic [3:0] LONG_BREAK_EXTRA = 4'h1;
  localparam logic [3:0] RUN_MAX = 4'hf;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic spare;
    logic receiver_standby;
    logic parity_odd;
    logic parity_enable;
    logic ten_bit_select;
    logic nine_bit;
    logic rx_enable;
    logic tx_enable;
  } ctrl_s;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;

endpackage : uart_s2_pkg

// [steady_bit_counter.sv]
`timescale 1ns/100ps
module steady_bit_counter (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Line
  input wire logic i_enable,
  input wire logic i_level,
  input wire logic [15:0] i_div,
  // Run length in bit times
  output logic [3:0] o_bits,
  output logic o_tick
);
  logic level_prev_r;
  logic [15:0] cyc_r;
  logic [3:0] bits_r;
  logic tick_r;
  wire restart = ~i_enable | (i_level != level_prev_r);
  wire wrap = cyc_r == (i_div - 16'h0001);
  wire grow = wrap & ~restart & (bits_r != uart_s2_pkg::RUN_MAX);
  // The restart sample already counts as the first cycle of the new level
  wire [15:0] cyc_nxt = restart ? 16'h0001 : (wrap ? 16'h0000 : cyc_r + 16'h0001);
  wire [3:0] bits_nxt = restart ? 4'h0 : (grow ? bits_r + 4'h1 : bits_r);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      level_prev_r <= 1'b1;
      cyc_r <= 16'h0000;
      bits_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      level_prev_r <= i_level;
      cyc_r <= cyc_nxt;
      bits_r <= bits_nxt;
      tick_r <= grow;
    end
  end

  assign o_bits = bits_r;
  assign o_tick = tick_r;
endmodule : steady_bit_counter

// [uart_s2_top.sv]
// Local design decision: the APB slave port.
`timescale 1ns/100ps
// How it works
// - Break flag sets on long-break detection; writing one clears it.
// - Edge flag sets on falling line edge, rising when inverted; write one clears.
// - Long-break threshold is one bit time above the normal break length.
// - Framing errors are not reported while long-break detection is on.
// - Bit-order zero: bit0 goes first after start, first received is bit0.
// - Bit-order one: top data bit goes first and is received first.
// - Reversal keeps polarity, parity position, start and stop positions.
// - Receive inversion applies to data, start, stop, break and idle.
// - In standby, waking idle sets the idle flag only if enabled.
// - Long-break detection blocks framing-error and receive-full flags.
// - Eight data bits, one stop: break flag at 11 bit times in long mode; no break flag when long mode is off.
// - Receiver-active sets at a valid start bit, clears at idle line.
module uart_s2_top (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Serial line
  input wire logic I_RXD,
  output logic O_TXD,
  // Interrupt
  output logic O_IRQ
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  uart_s2_pkg::ctrl_s ctrl_r, ctrl_nxt;
  logic [15:0] baud_r;
  logic [7:0] mask_r;
  logic [uart_s2_pkg::S1_W-1:0] s1_r, s1_nxt;
  logic brk_r, edge_r, bit_order_reverse_r, receive_invert_r, wake_r, long_break_detect_enable_r, raf_r;
  logic [31:0] prdata_r;
  uart_s2_pkg::rx_state_e rx_state_r, rx_state_nxt;
  uart_s2_pkg::tx_state_e tx_state_r, tx_state_nxt;
  logic [15:0] rx_cyc_r, rx_cyc_nxt, tx_cyc_r, tx_cyc_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt, run_bits;
  logic [9:0] rx_data_r, rx_sh_r, rx_sh_nxt, tx_sh_r;
  logic rxd_prev_r, rx_par_r, rx_par_nxt, rx_done, rx_start_ok, txd_r, txd_nxt, tx_done, run_tick;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = I_PSEL & ~I_PENABLE;
  wire access = I_PSEL & I_PENABLE;
  wire wr = access & I_PWRITE;
  wire rd = access & ~I_PWRITE;
  wire [5:0] idx = I_PADDR[7:2];
  wire aligned = I_PADDR[1:0] == 2'b00;
  wire hit_ctrl = aligned & (idx == uart_s2_pkg::IDX_CTRL);
  wire hit_baud = aligned & (idx == uart_s2_pkg::IDX_BAUD);
  wire hit_data = aligned & (idx == uart_s2_pkg::IDX_DATA);
  wire hit_s1 = aligned & (idx == uart_s2_pkg::IDX_STAT1);
  wire hit_mask = aligned & (idx == uart_s2_pkg::IDX_MASK);
  wire hit_s2 = aligned & (idx == uart_s2_pkg::IDX_STAT2);
  wire mapped = hit_ctrl | hit_baud | hit_data | hit_s1 | hit_mask | hit_s2;
  wire wr_s2 = wr & hit_s2;
  wire wr_s1 = wr & hit_s1;
  wire rd_data = rd & hit_data;
  wire tx_busy = tx_state_r != uart_s2_pkg::TX_IDLE;
  wire [7:0] s2_rd = {brk_r, edge_r, bit_order_reverse_r, receive_invert_r, wake_r, 1'b0, long_break_detect_enable_r, raf_r};
  wire [7:0] s1_rd = {2'b00, ~tx_busy, s1_r};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_r} :
                       hit_baud ? {16'h0000, baud_r} :
                       hit_data ? {22'h0, rx_data_r} :
                       hit_s1 ? {24'h000000, s1_rd} :
                       hit_mask ? {24'h000000, mask_r} :
                       hit_s2 ? {24'h000000, s2_rd} : 32'h00000000;

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access & ~mapped;
  assign O_PRDATA = prdata_r;

  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  wire [3:0] char_bits = uart_s2_pkg::BASE_CHAR_BITS + {3'b000, ctrl_r.nine_bit} + {3'b000, ctrl_r.ten_bit_select};
  wire [3:0] data_bits = char_bits - {3'b000, ctrl_r.parity_enable};
  wire [3:0] norm_bits = char_bits + uart_s2_pkg::FRAME_OVERHEAD;
  wire [3:0] brk_thr = norm_bits + uart_s2_pkg::LONG_BREAK_EXTRA;
  wire [9:0] data_mask = ~(10'h3ff << data_bits);
  wire [15:0] half_bit = {1'b0, baud_r[15:1]};
  wire [15:0] last_cyc = baud_r - 16'h0001;

  // ----------------------------------------
  // Receive line conditioning
  // ----------------------------------------
  // One inverted line for all uses
  wire rxd = I_RXD ^ receive_invert_r;
  wire rx_fall = rxd_prev_r & ~rxd;
  wire rx_en = ctrl_r.rx_enable;
  wire standby = ctrl_r.receiver_standby;

  steady_bit_counter u_run (
    .i_clock(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_enable(rx_en),
    .i_level(rxd),
    .i_div(baud_r),
    .o_bits(run_bits),
    .o_tick(run_tick)
  );

  // Long break seen on the line
  wire break_ev = long_break_detect_enable_r & rx_en & ~rxd & run_tick & (run_bits == brk_thr);
  wire idle_ev = rx_en & rxd & run_tick & (run_bits == norm_bits) & raf_r;
  wire idle_set = idle_ev & (~standby | wake_r);

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Arrival order into shift
  wire [9:0] rx_word = bit_order_reverse_r ? rx_sh_r : (rx_sh_r >> (4'ha - data_bits));
  wire rx_pe = ctrl_r.parity_enable & (rx_par_r != (^rx_word ^ ctrl_r.parity_odd));
  wire rx_mid = rx_cyc_r == last_cyc;

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_cyc_nxt = rx_cyc_r + 16'h0001;
    rx_cnt_nxt = rx_cnt_r;
    rx_sh_nxt = rx_sh_r;
    rx_par_nxt = rx_par_r;
    rx_done = 1'b0;
    rx_start_ok = 1'b0;
    case (rx_state_r)
      uart_s2_pkg::RX_IDLE: begin
        rx_cyc_nxt = 16'h0000;
        if (rx_fall) begin
          rx_state_nxt = uart_s2_pkg::RX_START;
        end
      end
      uart_s2_pkg::RX_START: begin
        if (rx_cyc_r == half_bit) begin
          rx_cyc_nxt = 16'h0000;
          rx_cnt_nxt = 4'h0;
          rx_sh_nxt = 10'h000;
          rx_start_ok = ~rxd;
          rx_state_nxt = rxd ? uart_s2_pkg::RX_IDLE : uart_s2_pkg::RX_DATA;
        end
      end
      uart_s2_pkg::RX_DATA: begin
        if (rx_mid) begin
          rx_cyc_nxt = 16'h0000;
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          rx_sh_nxt = bit_order_reverse_r ? {rx_sh_r[8:0], rxd} : {rxd, rx_sh_r[9:1]};
          if (rx_cnt_r == data_bits - 4'h1) begin
            rx_state_nxt = ctrl_r.parity_enable ? uart_s2_pkg::RX_PAR : uart_s2_pkg::RX_STOP;
          end
        end
      end
      uart_s2_pkg::RX_PAR: begin
        if (rx_mid) begin
          rx_cyc_nxt = 16'h0000;
          rx_par_nxt = rxd;
          rx_state_nxt = uart_s2_pkg::RX_STOP;
        end
      end
      uart_s2_pkg::RX_STOP: begin
        if (rx_mid) begin
          rx_done = 1'b1;
          rx_state_nxt = uart_s2_pkg::RX_IDLE;
        end
      end
      default: begin
        rx_state_nxt = uart_s2_pkg::RX_IDLE;
      end
    endcase
    if (!rx_en) begin
      rx_state_nxt = uart_s2_pkg::RX_IDLE;
      rx_done = 1'b0;
      rx_start_ok = 1'b0;
    end
  end

  // Receive-full held off in long-break mode
  wire receive_full_flag_set = rx_done & ~long_break_detect_enable_r & ~standby;
  wire fe_set = rx_done & ~rxd & ~long_break_detect_enable_r & ~standby;
  wire pf_set = rx_done & rx_pe & ~standby;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire tx_load = wr & hit_data & ctrl_r.tx_enable & ~tx_busy;
  wire tx_end = tx_cyc_r == last_cyc;
  wire [3:0] tx_idx = bit_order_reverse_r ? (data_bits - 4'h1 - tx_cnt_r) : tx_cnt_r;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_cyc_nxt = tx_end ? 16'h0000 : tx_cyc_r + 16'h0001;
    tx_cnt_nxt = tx_cnt_r;
    txd_nxt = 1'b1;
    tx_done = 1'b0;
    case (tx_state_r)
      uart_s2_pkg::TX_IDLE: begin
        tx_cyc_nxt = 16'h0000;
        if (tx_load) begin
          tx_state_nxt = uart_s2_pkg::TX_START;
        end
      end
      uart_s2_pkg::TX_START: begin
        txd_nxt = 1'b0;
        tx_cnt_nxt = 4'h0;
        if (tx_end) begin
          tx_state_nxt = uart_s2_pkg::TX_DATA;
        end
      end
      uart_s2_pkg::TX_DATA: begin
        txd_nxt = tx_sh_r[tx_idx];
        if (tx_end) begin
          tx_cnt_nxt = tx_cnt_r + 4'h1;
          if (tx_cnt_r == data_bits - 4'h1) begin
            tx_state_nxt = ctrl_r.parity_enable ? uart_s2_pkg::TX_PAR : uart_s2_pkg::TX_STOP;
          end
        end
      end
      uart_s2_pkg::TX_PAR: begin
        txd_nxt = ^tx_sh_r ^ ctrl_r.parity_odd;
        if (tx_end) begin
          tx_state_nxt = uart_s2_pkg::TX_STOP;
        end
      end
      uart_s2_pkg::TX_STOP: begin
        if (tx_end) begin
          tx_done = 1'b1;
          tx_state_nxt = uart_s2_pkg::TX_IDLE;
        end
      end
      default: begin
        tx_state_nxt = uart_s2_pkg::TX_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Flags and controls
  // ----------------------------------------
  wire [uart_s2_pkg::S1_W-1:0] s1_set = {tx_done, receive_full_flag_set, idle_set, fe_set, pf_set};
  wire [uart_s2_pkg::S1_W-1:0] s1_clr = (wr_s1 ? I_PWDATA[uart_s2_pkg::S1_W-1:0] : 5'h00) |
                                        (rd_data ? 5'h08 : 5'h00);
  // Set wins over a clear in the same cycle
  assign s1_nxt = s1_set | (s1_r & ~s1_clr);
  wire brk_nxt = break_ev | (brk_r & ~(wr_s2 & I_PWDATA[uart_s2_pkg::S2_BRK]));
  wire edge_nxt = rx_fall | (edge_r & ~(wr_s2 & I_PWDATA[uart_s2_pkg::S2_EDGE]));
  // Active from valid start to idle
  wire raf_nxt = rx_start_ok | (raf_r & ~idle_ev);

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr & hit_ctrl) begin
      ctrl_nxt = uart_s2_pkg::ctrl_s'(I_PWDATA[7:0]);
    end
    if (idle_ev) begin
      ctrl_nxt.receiver_standby = 1'b0;
    end
  end

  assign O_IRQ = |({brk_r, edge_r, 1'b0, s1_r} & mask_r);
  assign O_TXD = txd_r;

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_r <= uart_s2_pkg::ctrl_s'(uart_s2_pkg::CTRL_RST);
      baud_r <= uart_s2_pkg::BAUD_RST;
      mask_r <= uart_s2_pkg::MASK_RST;
      s1_r <= 5'h00;
      {brk_r, edge_r, raf_r} <= 3'b000;
      {bit_order_reverse_r, receive_invert_r, wake_r, long_break_detect_enable_r} <= 4'h0;
      prdata_r <= 32'h00000000;
      rxd_prev_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      baud_r <= (wr & hit_baud) ? I_PWDATA[15:0] : baud_r;
      mask_r <= (wr & hit_mask) ? I_PWDATA[7:0] : mask_r;
      s1_r <= s1_nxt;
      {brk_r, edge_r, raf_r} <= {brk_nxt, edge_nxt, raf_nxt};
      if (wr_s2) begin
        bit_order_reverse_r <= I_PWDATA[uart_s2_pkg::S2_BIT_ORDER_REVERSE];
        receive_invert_r <= I_PWDATA[uart_s2_pkg::S2_RECEIVE_INVERT];
        wake_r <= I_PWDATA[uart_s2_pkg::S2_WAKE];
        long_break_detect_enable_r <= I_PWDATA[uart_s2_pkg::S2_LONG_BREAK_DETECT_ENABLE];
      end
      prdata_r <= setup ? rd_mux : prdata_r;
      rxd_prev_r <= rxd;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rx_state_r <= uart_s2_pkg::RX_IDLE;
      {rx_cyc_r, rx_cnt_r, rx_sh_r, rx_par_r} <= 31'h00000000;
      rx_data_r <= 10'h000;
    end else begin
      rx_state_r <= rx_state_nxt;
      {rx_cyc_r, rx_cnt_r, rx_sh_r, rx_par_r} <= {rx_cyc_nxt, rx_cnt_nxt, rx_sh_nxt, rx_par_nxt};
      rx_data_r <= receive_full_flag_set ? (rx_word & data_mask) : rx_data_r;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tx_state_r <= uart_s2_pkg::TX_IDLE;
      {tx_cyc_r, tx_cnt_r} <= 20'h00000;
      tx_sh_r <= 10'h000;
      txd_r <= 1'b1;
    end else begin
      tx_state_r <= tx_state_nxt;
      {tx_cyc_r, tx_cnt_r} <= {tx_cyc_nxt, tx_cnt_nxt};
      tx_sh_r <= tx_load ? (I_PWDATA[9:0] & data_mask) : tx_sh_r;
      txd_r <= txd_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);

  a_break_sets: assert property (break_ev |=> brk_r && O_IRQ == mask_r[7]) else $error("break flag lost");
  a_break_mode: assert property ($rose(brk_r) |-> $past(long_break_detect_enable_r) && $past(run_bits) == $past(norm_bits) + 4'h1)
    else $error("break raised without long mode or at wrong length");
  a_edge_pin: assert property ((I_RXD != $past(I_RXD)) && (I_RXD == receive_invert_r) && $stable(receive_invert_r) |=> edge_r)
    else $error("active edge missed");
  a_fe_inhibit: assert property (long_break_detect_enable_r |=> !$rose(s1_r[1])) else $error("framing error in long mode");
  a_receive_full_flag_inhibit: assert property (long_break_detect_enable_r && $stable(long_break_detect_enable_r) |-> !$rose(s1_r[uart_s2_pkg::S1_RECEIVE_FULL_FLAG]))
    else $error("receive full in long break mode");
  a_lsb_first: assert property ((tx_state_r == uart_s2_pkg::TX_START) && tx_end && !bit_order_reverse_r |=> ##1 O_TXD == tx_sh_r[0])
    else $error("first data bit not bit0");
  a_msb_first: assert property ((tx_state_r == uart_s2_pkg::TX_START) && tx_end && bit_order_reverse_r
    |=> ##1 O_TXD == tx_sh_r[data_bits - 4'h1])
    else $error("first data bit not msb");
  a_start_inv: assert property (rx_en && (rx_state_r == uart_s2_pkg::RX_IDLE) && rxd_prev_r
    && (I_RXD == receive_invert_r) |=> rx_state_r == uart_s2_pkg::RX_START)
    else $error("start not seen through inversion");
  a_wake_idle: assert property (idle_ev && standby && !wake_r |=> !$rose(s1_r[2]))
    else $error("idle flag set in standby without wake control");
  a_raf_start: assert property ($rose(raf_r) |-> $past(rx_state_r) == uart_s2_pkg::RX_START)
    else $error("active flag raised without start bit");

  c_break: cover property (break_ev);
  c_idle_wake: cover property (idle_ev && standby);
  c_rx_char: cover property (receive_full_flag_set && bit_order_reverse_r);
  c_tx_done: cover property (tx_done);

endmodule : uart_s2_top

// [uart_line_model.sv]
`timescale 1ns/100ps
module uart_line_model (
  // Clock
  input wire logic i_clock,
  // Serial line
  input wire logic i_line,
  output logic o_line
);
  int bit_cyc = 4;
  logic idle_lvl = 1'b1;
  logic [7:0] rx_q = 8'h00;
  int rx_cnt = 0;
  int stop_bad = 0;

  initial o_line = 1'b1;

  // ----------------------------------------
  // Sending side
  // ----------------------------------------
  task automatic hold(input logic v, input int n);
    o_line <= v;
    repeat (n * bit_cyc) @(posedge i_clock);
  endtask : hold

  // Idle level flips when the node talks to an inverting receiver
  task automatic set_idle(input logic v);
    idle_lvl = v;
    @(posedge i_clock);
    o_line <= v;
  endtask : set_idle

  task automatic send(input logic [7:0] d, input bit msb);
    @(posedge i_clock);
    hold(~idle_lvl, 1);
    for (int i = 0; i < 8; i++) begin
      hold(d[msb ? 7 - i : i] ^ ~idle_lvl, 1);
    end
    hold(idle_lvl, 1);
  endtask : send

  // Active level for n bit times, then one idle bit
  task automatic send_low(input int n);
    @(posedge i_clock);
    hold(~idle_lvl, n);
    hold(idle_lvl, 1);
  endtask : send_low

  // ----------------------------------------
  // Receiving side: bits stored in arrival order
  // ----------------------------------------
  always begin
    @(negedge i_line);
    repeat (bit_cyc / 2) @(posedge i_clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge i_clock);
      rx_q[i] = i_line;
    end
    repeat (bit_cyc) @(posedge i_clock);
    if (i_line !== 1'b1) begin
      stop_bad++;
    end
    rx_cnt++;
  end
endmodule : uart_line_model

// [tb_top.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam logic [7:0] A_CTRL = {uart_s2_pkg::IDX_CTRL, 2'h0};
  localparam logic [7:0] A_BAUD = {uart_s2_pkg::IDX_BAUD, 2'h0};
  localparam logic [7:0] A_DATA = {uart_s2_pkg::IDX_DATA, 2'h0};
  localparam logic [7:0] A_ST1 = {uart_s2_pkg::IDX_STAT1, 2'h0};
  localparam logic [7:0] A_MASK = {uart_s2_pkg::IDX_MASK, 2'h0};
  localparam logic [7:0] A_ST2 = {uart_s2_pkg::IDX_STAT2, 2'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd;
  logic txd;
  logic irq;
  logic [31:0] q;
  logic err;
  int c;
  int num_errors = 0;
  int checks = 0;

  always #2 clk = ~clk;

  uart_s2_top dut (.I_CLOCK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_RXD(rxd), .O_TXD(txd), .O_IRQ(irq));
  uart_line_model peer (.i_clock(clk), .i_line(txd), .o_line(rxd));

  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic gap(input int n);
    repeat (n * 4) @(posedge clk);
  endtask : gap

  task automatic tx_wait(input int n);
    for (int k = 0; k < 300 && peer.rx_cnt == n; k++) @(posedge clk);
    if (peer.rx_cnt == n) begin
      num_errors++;
    end
  endtask : tx_wait

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    #200000;
    num_errors++;
    test_done();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTRL);
    `CHK("ctrl", 32'h0, q)
    rd(A_BAUD);
    `CHK("baud", 32'h10, q)
    rd(A_MASK);
    `CHK("mask", 32'h0, q)
    rd(A_ST2);
    `CHK("s2", 32'h0, q)
    rd(8'h30);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, q)
    endt("reset");
    wr(A_BAUD, 32'h4);
    wr(A_CTRL, 32'h3);
    c = peer.rx_cnt;
    wr(A_DATA, 32'h13);
    tx_wait(c);
    `CHK("tx lsb", 8'h13, peer.rx_q)
    peer.send(8'h13, 1'b0);
    rd(A_DATA);
    `CHK("rx lsb", 32'h13, q)
    wr(A_CTRL, 32'h0);
    wr(A_ST2, 32'h20);
    wr(A_CTRL, 32'h3);
    c = peer.rx_cnt;
    wr(A_DATA, 32'h13);
    tx_wait(c);
    `CHK("tx msb", 8'hc8, peer.rx_q)
    `CHK("stop", 0, peer.stop_bad)
    peer.send(8'h13, 1'b1);
    rd(A_DATA);
    `CHK("rx msb", 32'h13, q)
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h13);
    c = peer.rx_cnt;
    wr(A_DATA, 32'h13);
    tx_wait(c);
    `CHK("tx par", 8'he4, peer.rx_q)
    peer.send(8'he4, 1'b0);
    rd(A_DATA);
    `CHK("rx par", 32'h13, q)
    rd(A_ST1);
    `CHK("pf ok", 1'b0, q[0])
    peer.send(8'h64, 1'b0);
    rd(A_ST1);
    `CHK("pf bad", 1'b1, q[0])
    wr(A_CTRL, 32'h0);
    wr(A_ST2, 32'h0);
    wr(A_CTRL, 32'h3);
    endt("order");
    wr(A_ST2, 32'h40);
    rd(A_ST2);
    `CHK("edge clr", 1'b0, q[6])
    peer.send(8'hff, 1'b0);
    rd(A_ST2);
    `CHK("edge set", 1'b1, q[6])
    wr(A_ST2, 32'h40);
    rd(A_DATA);
    endt("edge");
    peer.send_low(10);
    rd(A_ST1);
    `CHK("fe normal", 1'b1, q[1])
    wr(A_ST1, 32'h1f);
    rd(A_DATA);
    wr(A_ST2, 32'h2);
    peer.send_low(10);
    gap(1);
    rd(A_ST1);
    `CHK("fe receive_full_flag long", 2'b00, {q[3], q[1]})
    rd(A_ST2);
    `CHK("brk 10", 1'b0, q[7])
    peer.send_low(12);
    rd(A_ST2);
    `CHK("brk 12", 1'b1, q[7])
    `CHK("irq masked", 1'b0, irq)
    wr(A_MASK, 32'h80);
    @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    wr(A_ST2, 32'h82);
    rd(A_ST2);
    `CHK("brk w1c", 1'b0, q[7])
    `CHK("irq off", 1'b0, irq)
    wr(A_MASK, 32'h0);
    wr(A_ST2, 32'h0);
    endt("break");
    wr(A_CTRL, 32'h1);
    wr(A_ST2, 32'h10);
    peer.set_idle(1'b0);
    wr(A_CTRL, 32'h3);
    wr(A_ST2, 32'h50);
    rd(A_ST2);
    `CHK("edge inv clr", 1'b0, q[6])
    peer.send(8'h13, 1'b0);
    rd(A_ST2);
    `CHK("edge inv", 1'b1, q[6])
    rd(A_DATA);
    `CHK("rx inv", 32'h13, q)
    wr(A_CTRL, 32'h1);
    wr(A_ST2, 32'h0);
    peer.set_idle(1'b1);
    wr(A_CTRL, 32'h3);
    wr(A_ST2, 32'h40);
    endt("invert");
    wr(A_ST1, 32'h1f);
    wr(A_CTRL, 32'h43);
    fork
      peer.send(8'h5a, 1'b0);
      begin
        gap(3);
        rd(A_ST2);
        `CHK("active", 1'b1, q[0])
      end
    join
    gap(14);
    rd(A_CTRL);
    `CHK("woken", 1'b0, q[6])
    rd(A_ST1);
    `CHK("idle off", 1'b0, q[2])
    rd(A_ST2);
    `CHK("inactive", 1'b0, q[0])
    wr(A_CTRL, 32'h1);
    wr(A_ST2, 32'h8);
    wr(A_CTRL, 32'h43);
    peer.send(8'h5a, 1'b0);
    gap(14);
    rd(A_ST1);
    `CHK("idle on", 1'b1, q[2])
    endt("standby");
    test_done();
  end
endmodule : tb_top
